// ---- pioc_io_cell.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.vh"

// Summary of operation
// - One register per pin, configured as input capture or output register.
// - Each pin is configured input-only, output-only or bidirectional.
// - Every pin has its own output enable turning its driver on or off.
// - Open-drain: drive only low, enable asserted only while driving low.
// - Base and enhanced variants share the same open-drain output mode.
// - Data and enable from routing pass a selectable inverter.
// - Register takes its configured high or low value when configuration finishes.
// - Register configured to start low can be cleared asynchronously once configuration is live.
// - Base variant: register starting high ignores asynchronous clear and preset.
// - Enhanced variant: register starting high is preset asynchronously to one.
// - Fast bidirectional pins keep enable and input registers in neighbouring logic cells.
// - Clock enable delay offers bypass or three increasing delay levels.
// - Fast pins feed clock, clear or fanout signals inward and can drive out.
// - Fast pin output data and enable come from neighbouring local routing.
// - Pins bordering the differential block are input-only, enable never asserted.
module pioc_io_cell #(
  parameter WIDTH = 4,
  parameter ENHANCED = 1,
  parameter [WIDTH-1:0] FAST_MASK = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] BORDER_MASK = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Configuration
  input wire cfg_done,
  input wire [`PIOC_MODE_W*WIDTH-1:0] cfg_mode,
  input wire [WIDTH-1:0] cfg_reg_out,
  input wire [WIDTH-1:0] cfg_use_reg,
  input wire [WIDTH-1:0] cfg_open_drain,
  input wire [WIDTH-1:0] cfg_inv_data,
  input wire [WIDTH-1:0] cfg_inv_oe,
  input wire [WIDTH-1:0] cfg_init_high,
  input wire [WIDTH-1:0] cfg_fast_bidir,
  input wire [`PIOC_DLY_W*WIDTH-1:0] cfg_ce_dly,
  // Core side
  input wire [WIDTH-1:0] core_dout,
  input wire [WIDTH-1:0] core_oe,
  input wire [WIDTH-1:0] core_ce,
  input wire core_aclr,
  input wire core_apre,
  input wire [WIDTH-1:0] local_dout,
  input wire [WIDTH-1:0] local_oe,
  output wire [WIDTH-1:0] core_din,
  output wire [WIDTH-1:0] core_rin,
  output wire [WIDTH-1:0] fast_net,
  // Pin side
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] pin_o,
  output wire [WIDTH-1:0] pin_oe
);

  reg cfg_done_s1_q;
  reg cfg_done_s2_q;
  reg cfg_done_s3_q;
  reg cfg_live_q;
  reg cfg_done_last_q;
  wire cfg_load;

  // The configuration-done level is treated as foreign and synchronised too.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_done_s1_q <= 1'b0;
      cfg_done_s2_q <= 1'b0;
      cfg_done_s3_q <= 1'b0;
      cfg_live_q <= 1'b0;
      cfg_done_last_q <= 1'b0;
    end else begin
      cfg_done_s1_q <= cfg_done;
      cfg_done_s2_q <= cfg_done_s1_q;
      cfg_done_s3_q <= cfg_done_s2_q;
      if (cfg_done_s2_q == cfg_done_s3_q) begin
        cfg_live_q <= cfg_done_s3_q;
      end
      cfg_done_last_q <= cfg_live_q;
    end
  end

  assign cfg_load = cfg_live_q & ~cfg_done_last_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      wire [`PIOC_MODE_W-1:0] mode;
      wire is_fast;
      wire src_dout;
      wire src_oe;
      wire ce_dly;
      wire clr_en;
      wire pre_en;
      wire out_val;
      wire oe_want;
      reg oe_mode;
      reg in_s1_q;
      reg in_s2_q;
      reg in_s3_q;
      reg in_filt_q;
      reg cell_q;
      reg oe_lc_q;
      reg in_lc_q;
      reg pin_o_q;
      reg pin_oe_q;

      assign mode = cfg_mode[`PIOC_MODE_W*g +: `PIOC_MODE_W];
      assign is_fast = FAST_MASK[g];

      // Fast pins take data and enable from neighbouring local routing.
      assign src_dout = (is_fast ? local_dout[g] : core_dout[g]) ^ cfg_inv_data[g];
      assign src_oe = (is_fast ? local_oe[g] : core_oe[g]) ^ cfg_inv_oe[g];

      // Pin input synchroniser; a change counts once stages two and three agree.
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          in_s1_q <= 1'b0;
          in_s2_q <= 1'b0;
          in_s3_q <= 1'b0;
          in_filt_q <= 1'b0;
        end else begin
          in_s1_q <= pin_i[g];
          in_s2_q <= in_s1_q;
          in_s3_q <= in_s2_q;
          if (in_s2_q == in_s3_q) begin
            in_filt_q <= in_s3_q;
          end
        end
      end

      pioc_delay #(
        .DEPTH(`PIOC_DLY_MAX)
      ) u_ce_dly (
        .clk(clk),
        .nrst(nrst),
        .sig_i(core_ce[g]),
        .sel(cfg_ce_dly[`PIOC_DLY_W*g +: `PIOC_DLY_W]),
        .sig_o(ce_dly)
      );

      // The base variant leaves a start-high register without any async control.
      assign clr_en = core_aclr & ~cfg_init_high[g] & cfg_live_q;
      assign pre_en = core_apre & cfg_init_high[g] & cfg_live_q & (ENHANCED != 0);

      // The cell register; async clear and preset beat the clocked path.
      always @(posedge clk or negedge nrst or posedge clr_en or posedge pre_en) begin
        if (!nrst) begin
          cell_q <= `PIOC_RST_REG;
        end else if (clr_en) begin
          cell_q <= 1'b0;
        end else if (pre_en) begin
          cell_q <= 1'b1;
        end else if (cfg_load) begin
          cell_q <= cfg_init_high[g];
        end else if (cfg_live_q && ce_dly) begin
          cell_q <= cfg_reg_out[g] ? src_dout : in_filt_q;
        end
      end

      // Fast bidirectional pins register enable and input in logic cells beside the pin.
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          oe_lc_q <= `PIOC_RST_OE;
          in_lc_q <= `PIOC_RST_REG;
        end else begin
          oe_lc_q <= src_oe;
          in_lc_q <= in_filt_q;
        end
      end

      always @* begin
        case (mode)
          `PIOC_MODE_IN: oe_mode = 1'b0;
          `PIOC_MODE_OUT: oe_mode = 1'b1;
          `PIOC_MODE_BIDIR: oe_mode = cfg_fast_bidir[g] ? oe_lc_q : src_oe;
          default: oe_mode = 1'b0;
        endcase
      end

      assign out_val = (cfg_use_reg[g] & cfg_reg_out[g]) ? cell_q : src_dout;
      // Border pins never drive, and nothing drives before configuration ends.
      assign oe_want = oe_mode & cfg_live_q & ~BORDER_MASK[g];

      // Open drain drives only low; both variants do it in the output stage,
      // holding data low and driving the enable only while the output value is low.
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pin_o_q <= `PIOC_RST_PIN;
          pin_oe_q <= `PIOC_RST_OE;
        end else if (cfg_open_drain[g]) begin
          pin_o_q <= 1'b0;
          pin_oe_q <= oe_want & ~out_val;
        end else begin
          pin_o_q <= out_val;
          pin_oe_q <= oe_want;
        end
      end

      assign pin_o[g] = pin_o_q;
      assign pin_oe[g] = pin_oe_q;
      // The input path stays live whatever the enable does.
      assign core_din[g] = in_filt_q;
      assign core_rin[g] = cfg_fast_bidir[g] ? in_lc_q : (cfg_reg_out[g] ? 1'b0 : cell_q);
      assign fast_net[g] = is_fast & in_filt_q;
    end
  endgenerate

endmodule // pioc_io_cell

`default_nettype wire

// ---- pioc_consts.vh ----
`ifndef PIOC_CONSTS_VH
`define PIOC_CONSTS_VH

// Pin direction modes, two bits per pin.
`define PIOC_MODE_W 2
`define PIOC_MODE_IN 2'h0
`define PIOC_MODE_OUT 2'h1
`define PIOC_MODE_BIDIR 2'h2

// Clock enable delay settings, two bits per pin.
`define PIOC_DLY_W 2
`define PIOC_DLY_OFF 2'h0
`define PIOC_DLY_L1 2'h1
`define PIOC_DLY_L2 2'h2
`define PIOC_DLY_L3 2'h3
`define PIOC_DLY_MAX 3

// Reset and power-up values.
`define PIOC_RST_REG 1'h0
`define PIOC_RST_OE 1'h0
`define PIOC_RST_PIN 1'h0

`endif

// ---- pioc_delay.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pioc_consts.vh"

// Selectable delay of a single-bit signal: bypassed or one to three clock cycles.
module pioc_delay #(
  parameter DEPTH = `PIOC_DLY_MAX
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Signal and setting
  input wire sig_i,
  input wire [`PIOC_DLY_W-1:0] sel,
  output reg sig_o
);

  reg [DEPTH-1:0] tap_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tap_q <= {DEPTH{1'b0}};
    end else begin
      tap_q <= {tap_q[DEPTH-2:0], sig_i};
    end
  end

  always @* begin
    case (sel)
      `PIOC_DLY_OFF: sig_o = sig_i;
      `PIOC_DLY_L1: sig_o = tap_q[0];
      `PIOC_DLY_L2: sig_o = tap_q[1];
      `PIOC_DLY_L3: sig_o = tap_q[2];
      default: sig_o = sig_i;
    endcase
  end

endmodule // pioc_delay

`default_nettype wire

// ---- pioc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_model #(
  parameter WIDTH = 4
) (
  // Clock
  input wire clk,
  // Pin and board
  input wire [WIDTH-1:0] pin_o,
  input wire [WIDTH-1:0] pin_oe,
  input wire [WIDTH-1:0] ext_en,
  input wire [WIDTH-1:0] ext_val,
  input wire [WIDTH-1:0] pull_up,
  output wire [WIDTH-1:0] pin_i
);
  // A floating line without pull-up toggles so a stale level never looks valid.
  reg [WIDTH-1:0] wob_q = {WIDTH{1'b0}};
  always @(posedge clk) wob_q <= ~wob_q;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pull_up | wob_q));
endmodule // pioc_pin_model
`default_nettype wire

// ---- pioc_io_cell_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module pioc_io_cell_monitor #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] BORDER_MASK = 0
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Configuration and core
  input wire cfg_done,
  input wire [2*WIDTH-1:0] cfg_mode,
  input wire [WIDTH-1:0] cfg_reg_out,
  input wire [WIDTH-1:0] cfg_use_reg,
  input wire [WIDTH-1:0] cfg_open_drain,
  input wire [WIDTH-1:0] cfg_inv_data,
  input wire [WIDTH-1:0] cfg_inv_oe,
  input wire [WIDTH-1:0] cfg_init_high,
  input wire [WIDTH-1:0] core_dout,
  input wire [WIDTH-1:0] core_oe,
  input wire core_aclr,
  input wire core_apre,
  input wire [WIDTH-1:0] core_din,
  // Pin
  input wire [WIDTH-1:0] pin_i,
  input wire [WIDTH-1:0] pin_o,
  input wire [WIDTH-1:0] pin_oe
);
  reg [3:0] lc_q;
  // The enable, data, clear and preset checks wait well past the configuration synchroniser.
  wire live = lc_q > 4'h7;
  wire d1 = cfg_mode[3:2] == 2'h2 && !cfg_use_reg[1] && !cfg_open_drain[1];
  wire r2 = cfg_mode[5:4] == 2'h1 && cfg_use_reg[2] && cfg_reg_out[2] && !cfg_inv_data[2];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  always @(posedge clk or negedge nrst)
    if (!nrst) lc_q <= 4'h0;
    else lc_q <= cfg_done ? lc_q + {3'h0, lc_q != 4'hF} : 4'h0;
  property p_bd; (pin_oe & BORDER_MASK) == 0; endproperty
  a_bd: assert property (p_bd) else $error("border pin driven");
  property p_in; cfg_mode[1:0] == 2'h0 && $past(cfg_mode[1:0]) == 2'h0 |-> !pin_oe[0]; endproperty
  a_in: assert property (p_in) else $error("input pin driven");
  property p_oe; live && d1 && $past(d1) |-> pin_oe[1] == $past(core_oe[1] ^ cfg_inv_oe[1]);
  endproperty
  a_oe: assert property (p_oe) else $error("enable path wrong");
  property p_do; live && d1 && $past(d1) && pin_oe[1] |->
    pin_o[1] == $past(core_dout[1] ^ cfg_inv_data[1]); endproperty
  a_do: assert property (p_do) else $error("data path wrong");
  property p_od; (pin_oe & pin_o & cfg_open_drain & $past(cfg_open_drain)) == 0; endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_din; $stable(pin_i[0]) [*8] |-> core_din[0] == pin_i[0]; endproperty
  a_din: assert property (p_din) else $error("pin level lost");
  property p_clr; (live && r2 && !cfg_init_high[2] && core_aclr) [*3] |-> !pin_o[2]; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_pre; (live && r2 && cfg_init_high[2] && core_apre) [*3] |-> pin_o[2]; endproperty
  a_pre: assert property (p_pre) else $error("preset ignored");
  c_od: cover property (pin_oe[1] && cfg_open_drain[1]);
  c_clr: cover property (live && core_aclr && !cfg_init_high[2]);
  c_pre: cover property (live && core_apre);
endmodule // pioc_io_cell_monitor
`default_nettype wire

// ---- pioc_io_cell_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pioc_io_cell_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg cfg_done = 1'b0;
  reg aclr = 1'b0;
  reg apre = 1'b0;
  reg [3:0] od = 4'h0, inv_d = 4'h0, inv_oe = 4'h0, init_hi = 4'h0, ce = 4'h0;
  reg [3:0] dout = 4'h0, oe = 4'hA, ext_val = 4'h0;
  reg [7:0] dly = 8'h00;
  // Pin 1 is bidirectional so that its enable follows the core; pins 2 and 3 are outputs.
  reg [7:0] mode = 8'h58;
  reg [3:0] rout = 4'h4, ureg = 4'h4, fbd = 4'h0, ext_en = 4'h1, ldout = 4'h0, loe = 4'h0;
  wire [3:0] din, rin, po, poe, pi, fnet;
  integer errors = 0, n_tests = 0, i, n;
  always #12.5 clk = ~clk;
  pioc_io_cell #(.WIDTH(4), .ENHANCED(1), .FAST_MASK(4'h1), .BORDER_MASK(4'h8)) DUT (
    .clk(clk), .nrst(nrst),
    .cfg_done(cfg_done), .cfg_mode(mode), .cfg_reg_out(rout), .cfg_use_reg(ureg),
    .cfg_open_drain(od), .cfg_inv_data(inv_d), .cfg_inv_oe(inv_oe), .cfg_init_high(init_hi),
    .cfg_fast_bidir(fbd), .cfg_ce_dly(dly), .core_dout(dout), .core_oe(oe), .core_ce(ce),
    .core_aclr(aclr), .core_apre(apre), .local_dout(ldout), .local_oe(loe), .core_din(din),
    .core_rin(rin), .fast_net(fnet), .pin_i(pi), .pin_o(po), .pin_oe(poe));
  pioc_pin_model #(.WIDTH(4)) PIN (.clk(clk), .pin_o(po), .pin_oe(poe), .ext_en(ext_en),
    .ext_val(ext_val), .pull_up(od), .pin_i(pi));
  task chk(input [63:0] nm, input [3:0] e, input [3:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tk(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    tk(20);
    @(posedge clk) nrst <= 1'b1;
    tk(4);
    chk("noconf", 4'h0, poe);
    @(posedge clk) cfg_done <= 1'b1;
    tk(10);
    chk("init", 4'h0, po & 4'h4);
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk) {inv_oe[1], inv_d[1], oe[1], dout[1]} <= i[3:0];
      tk(1);
      chk("oe", {2'h1, i[1] ^ i[3], 1'h0}, poe);
      chk("dout", {2'h0, (i[0] ^ i[2]) & (i[1] ^ i[3]), 1'h0}, po & poe & 4'h2);
    end
    @(posedge clk) {inv_oe, inv_d, od} <= 12'h002;
    tk(8);
    chk("od_off", 4'h0, poe & 4'h2);
    chk("od_pull", 4'h2, din & 4'h2);
    @(posedge clk) dout[1] <= 1'b0;
    tk(1);
    chk("od_low", 4'h2, poe & ~po & 4'h2);
    @(posedge clk) {ext_val[0], ce[0]} <= 2'h3;
    tk(8);
    chk("din", 4'h1, din & 4'h1);
    chk("rin", 4'h1, rin & 4'h5);
    chk("fast_net", 4'h1, fnet);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk) dly[5:4] <= i[1:0];
      tk(4);
      @(posedge clk) {dout[2], ce[2]} <= {~dout[2], 1'b1};
      @(posedge clk) ce[2] <= 1'b0;
      n = 1;
      #1;
      while (po[2] !== dout[2] && n < 12) begin
        tk(1);
        n = n + 1;
      end
      chk("ce_dly", i[3:0] + 4'h2, n[3:0]);
      if (n == 12) print_verdict;
    end
    @(posedge clk) {dout[2], ce[2]} <= 2'h3;
    tk(8);
    // Clock enable stays high so the clear must win over the clocked load.
    @(posedge clk) aclr <= 1'b1;
    tk(3);
    chk("aclr", 4'h0, po & 4'h4);
    @(posedge clk) {aclr, ce[2], dout[2], cfg_done, init_hi} <= 8'h04;
    tk(4);
    @(posedge clk) cfg_done <= 1'b1;
    tk(10);
    chk("init_hi", 4'h4, po & 4'h4);
    @(posedge clk) aclr <= 1'b1;
    tk(3);
    chk("aclr_hi", 4'h4, po & 4'h4);
    @(posedge clk) {aclr, ce[2]} <= 2'h1;
    tk(8);
    chk("load0", 4'h0, po & 4'h4);
    @(posedge clk) apre <= 1'b1;
    tk(3);
    chk("apre", 4'h4, po & 4'h4);
    // Pin 0 is a fast pin: as a bidirectional pin it must follow the local routing only.
    @(posedge clk) {mode[1:0], ldout[0], loe[0]} <= 4'hB;
    tk(1);
    chk("fast_oe", 4'h1, poe & po & 4'h1);
    // The neighbouring enable flop adds one cycle before the driver lets go.
    @(posedge clk) {fbd[0], loe[0]} <= 2'h2;
    tk(1);
    chk("lc_oe1", 4'h1, poe & 4'h1);
    tk(1);
    chk("lc_oe2", 4'h0, poe & 4'h1);
    // With the cell register frozen, only the neighbouring input flop can carry the pin to core_rin.
    @(posedge clk) {ext_val[0], ce[0]} <= 2'h0;
    tk(8);
    chk("lc_rin", 4'h0, rin & 4'h1);
    chk("lc_din", 4'h0, din & 4'h1);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    print_verdict;
  end
endmodule // pioc_io_cell_tb
bind pioc_io_cell pioc_io_cell_monitor #(.WIDTH(WIDTH), .BORDER_MASK(BORDER_MASK)) MON (
  .clk(clk), .nrst(nrst), .cfg_done(cfg_done), .cfg_mode(cfg_mode), .cfg_reg_out(cfg_reg_out),
  .cfg_use_reg(cfg_use_reg), .cfg_open_drain(cfg_open_drain), .cfg_inv_data(cfg_inv_data),
  .cfg_inv_oe(cfg_inv_oe), .cfg_init_high(cfg_init_high), .core_dout(core_dout),
  .core_oe(core_oe), .core_aclr(core_aclr), .core_apre(core_apre), .core_din(core_din),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
`default_nettype wire
